/* File: core/adcs_consts.svh */
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH
// Register byte offsets
`define ADCS_OFS_CTRL 8'h00
`define ADCS_OFS_CFG 8'h04
`define ADCS_OFS_CREF 8'h08
`define ADCS_OFS_RHI 8'h0c
`define ADCS_OFS_RLO 8'h10
`define ADCS_OFS_IRQ 8'h14
// Control register fields
`define ADCS_CTRL_START 7
`define ADCS_CTRL_BUSY 6
`define ADCS_CTRL_PWR 5
`define ADCS_CTRL_FMT 4
// Config register fields
`define ADCS_CFG_INSEL_LSB 5
`define ADCS_CFG_REF_LSB 3
`define ADCS_CFG_CK_LSB 0
// Current reference control and interrupt control fields
`define ADCS_CREF_ACCM 0
`define ADCS_IRQ_ADE 0
`define ADCS_IRQ_EMI 1
`define ADCS_IRQ_FLAG 2
// Reset values
`define ADCS_RST_REG 8'h00
// Conversion timing in converter clocks, accumulate count, full-scale code
`define ADCS_SAMPLE_CLKS 4'h4
`define ADCS_CONV_CLKS 4'hc
`define ADCS_ACC_COUNT 5'h10
`define ADCS_FULL_SCALE 12'hfff
// Recommended converter clock period window, software side
`define ADCS_SYS_CLK_NS 40
`define ADCS_CK_MIN_NS 500
`define ADCS_CK_MAX_NS 10000
`define ADCS_CK_MIN_CYC ((`ADCS_CK_MIN_NS + `ADCS_SYS_CLK_NS - 1) / `ADCS_SYS_CLK_NS)
`define ADCS_CK_MAX_CYC (`ADCS_CK_MAX_NS / `ADCS_SYS_CLK_NS)
// AXI responses
`define ADCS_RESP_OKAY 2'b00
`define ADCS_RESP_SLVERR 2'b10
`endif

/* File: core/adcs_pkg.sv */
package adcs_pkg;
   typedef enum logic [1:0] {ADCS_IDLE, ADCS_SAMPLE, ADCS_CONVERT} adcs_state_e;
   typedef logic [7:0] adcs_addr_t;
   typedef logic [11:0] adcs_code_t;
endpackage

/* File: core/adcs_sequencer.sv */
`include "adcs_consts.svh"
// How it works
// - Start bit high then low launches conversion
// - Busy set once conversion launched
// - Completion clears busy, sets interrupt flag
// - Interrupt needs global and converter enables
// - Converter clock divided from system clock
// - Four sampling plus twelve conversion clocks
// - Accumulate off: one start, one result
// - Accumulate on: sixteen conversions summed, 16-bit
// - Result layout depends on mode and format
// - Power enable low switches converter off
// - Each conversion is 12-bit unsigned, full scale fff
// - Divide by 1 to 128 for codes 0-7
// - Format selects high/low split of result with accumulate off; ignored with accumulate on
// - Disabled converter keeps result registers
// - Codes 1-4 internal, others external channel
module adcs_sequencer (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire adcs_pkg::adcs_addr_t s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire adcs_pkg::adcs_addr_t s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire adcs_pkg::adcs_code_t adc_code_i,
   output logic adc_power_o,
   output logic adc_sample_o,
   output logic adc_convert_o,
   output logic adc_clk_o,
   output logic [3:0] adc_ext_chan_o,
   output logic [2:0] adc_int_src_o,
   output logic adc_ref_int_o,
   output logic irq_o
);
   import adcs_pkg::*;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_full;
      logic w_full;
      adcs_addr_t aw_addr;
      logic [7:0] wbyte;
      logic wlane;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic start;
      logic power;
      logic fmt;
      logic [3:0] chan;
      logic [2:0] insel;
      logic [1:0] refsel;
      logic [2:0] cksel;
      logic accm;
      logic ade;
      logic global_irq_enable;
      logic irqf;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      adcs_state_e state;
      logic busy;
      logic [6:0] div;
      logic tick;
      logic [3:0] phase;
      logic [3:0] nconv;
      logic [15:0] sum;
      adcs_code_t code_s1;
      adcs_code_t code_s2;
      logic irq;
      logic sample;
      logic convert;
      logic [3:0] ext_chan;
      logic [2:0] int_src;
      logic ref_int;
   } adcs_regs_s;

   adcs_regs_s s;
   adcs_regs_s next_s;
   logic launch;
   logic done;
   logic capture;
   logic tick_now;
   logic [6:0] mask;
   logic wr_go;
   logic [15:0] new_sum;

   always_comb begin
      next_s = s;
      launch = 1'b0;
      done = 1'b0;
      capture = 1'b0;
      new_sum = s.sum + {4'h0, s.code_s2};
      // Only the low sel bits of the free counter matter
      mask = 7'h7f >> (3'h7 - s.cksel);
      tick_now = s.busy && ((s.div & mask) == mask);
      wr_go = s.aw_full && s.w_full && !s.bvalid;
      // Code comes from the analog side, so it is resynchronised
      next_s.code_s1 = adc_code_i;
      next_s.code_s2 = s.code_s1;

      // Write address and data are taken independently
      if (s_axi_awvalid_i && s.awready) begin
         next_s.aw_full = 1'b1;
         next_s.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s.wready) begin
         next_s.w_full = 1'b1;
         next_s.wbyte = s_axi_wdata_i[7:0];
         next_s.wlane = s_axi_wstrb_i[0];
      end
      if (s.bvalid && s_axi_bready_i) begin
         next_s.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_s.aw_full = 1'b0;
         next_s.w_full = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = `ADCS_RESP_OKAY;
         case (s.aw_addr)
            `ADCS_OFS_CTRL: begin
               if (s.wlane) begin
                  // Busy bit position ignored on write
                  next_s.start = s.wbyte[`ADCS_CTRL_START];
                  launch = s.start && !s.wbyte[`ADCS_CTRL_START];
                  next_s.power = s.wbyte[`ADCS_CTRL_PWR];
                  next_s.fmt = s.wbyte[`ADCS_CTRL_FMT];
                  next_s.chan = s.wbyte[3:0];
               end
            end
            `ADCS_OFS_CFG: begin
               if (s.wlane) begin
                  next_s.insel = s.wbyte[`ADCS_CFG_INSEL_LSB +: 3];
                  next_s.refsel = s.wbyte[`ADCS_CFG_REF_LSB +: 2];
                  next_s.cksel = s.wbyte[`ADCS_CFG_CK_LSB +: 3];
               end
            end
            `ADCS_OFS_CREF: begin
               if (s.wlane) begin
                  next_s.accm = s.wbyte[`ADCS_CREF_ACCM];
               end
            end
            `ADCS_OFS_IRQ: begin
               if (s.wlane) begin
                  next_s.ade = s.wbyte[`ADCS_IRQ_ADE];
                  next_s.global_irq_enable = s.wbyte[`ADCS_IRQ_EMI];
                  if (!s.wbyte[`ADCS_IRQ_FLAG]) begin
                     next_s.irqf = 1'b0;
                  end
               end
            end
            `ADCS_OFS_RHI, `ADCS_OFS_RLO: begin
            end
            default: begin
               next_s.bresp = `ADCS_RESP_SLVERR;
            end
         endcase
      end
      next_s.awready = !next_s.aw_full && !next_s.bvalid;
      next_s.wready = !next_s.w_full && !next_s.bvalid;

      // Read channel
      if (s.rvalid && s_axi_rready_i) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = `ADCS_RESP_OKAY;
         next_s.rdata = 32'h0000_0000;
         case (s_axi_araddr_i)
            `ADCS_OFS_CTRL: next_s.rdata[7:0] = {s.start, s.busy, s.power, s.fmt, s.chan};
            `ADCS_OFS_CFG: next_s.rdata[7:0] = {s.insel, s.refsel, s.cksel};
            `ADCS_OFS_CREF: next_s.rdata[7:0] = {7'h00, s.accm};
            `ADCS_OFS_RHI: next_s.rdata[7:0] = s.res_hi;
            `ADCS_OFS_RLO: next_s.rdata[7:0] = s.res_lo;
            `ADCS_OFS_IRQ: next_s.rdata[7:0] = {5'h00, s.irqf, s.global_irq_enable, s.ade};
            default: next_s.rresp = `ADCS_RESP_SLVERR;
         endcase
      end
      next_s.arready = !next_s.rvalid;

      // Sequencer
      next_s.div = s.div + 7'h01;
      next_s.tick = tick_now;
      if (!s.power) begin
         // Abort quietly; result pair is left alone
         next_s.state = ADCS_IDLE;
         next_s.busy = 1'b0;
      end else begin
         case (s.state)
            ADCS_IDLE: begin
               if (launch && !s.busy) begin
                  next_s.state = ADCS_SAMPLE;
                  next_s.busy = 1'b1;
                  next_s.div = 7'h00;
                  next_s.phase = 4'h0;
                  next_s.nconv = 4'h0;
                  next_s.sum = 16'h0000;
               end
            end
            ADCS_SAMPLE: begin
               if (tick_now) begin
                  if (s.phase == `ADCS_SAMPLE_CLKS - 4'h1) begin
                     next_s.state = ADCS_CONVERT;
                     next_s.phase = 4'h0;
                  end else begin
                     next_s.phase = s.phase + 4'h1;
                  end
               end
            end
            ADCS_CONVERT: begin
               if (tick_now) begin
                  if (s.phase == `ADCS_CONV_CLKS - 4'h1) begin
                     capture = 1'b1;
                     next_s.phase = 4'h0;
                     if (s.accm) begin
                        next_s.sum = new_sum;
                        if ({1'b0, s.nconv} == `ADCS_ACC_COUNT - 5'h01) begin
                           next_s.res_hi = new_sum[15:8];
                           next_s.res_lo = new_sum[7:0];
                           done = 1'b1;
                        end else begin
                           next_s.nconv = s.nconv + 4'h1;
                           next_s.state = ADCS_SAMPLE;
                        end
                     end else begin
                        done = 1'b1;
                        if (s.fmt) begin
                           next_s.res_hi = {4'h0, s.code_s2[11:8]};
                           next_s.res_lo = s.code_s2[7:0];
                        end else begin
                           next_s.res_hi = s.code_s2[11:4];
                           next_s.res_lo = {s.code_s2[3:0], 4'h0};
                        end
                     end
                     if (done) begin
                        next_s.state = ADCS_IDLE;
                        next_s.busy = 1'b0;
                     end
                  end else begin
                     next_s.phase = s.phase + 4'h1;
                  end
               end
            end
            default: begin
               next_s.state = ADCS_IDLE;
               next_s.busy = 1'b0;
            end
         endcase
      end
      // Completion wins over a simultaneous software clear
      if (done) begin
         next_s.irqf = 1'b1;
      end
      next_s.irq = next_s.irqf && next_s.ade && next_s.global_irq_enable;
      // Phase pins lag the state one cycle to line up with the clock pulse
      next_s.sample = s.state == ADCS_SAMPLE;
      next_s.convert = s.state == ADCS_CONVERT;
      next_s.ext_chan = next_s.chan;
      if (next_s.insel >= 3'h1 && next_s.insel <= 3'h4) begin
         next_s.int_src = next_s.insel;
      end else begin
         next_s.int_src = 3'h0;
      end
      next_s.ref_int = next_s.refsel == 2'b01;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s <= '0;
         s.state <= ADCS_IDLE;
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready_o = s.awready;
   assign s_axi_wready_o = s.wready;
   assign s_axi_bvalid_o = s.bvalid;
   assign s_axi_bresp_o = s.bresp;
   assign s_axi_arready_o = s.arready;
   assign s_axi_rvalid_o = s.rvalid;
   assign s_axi_rresp_o = s.rresp;
   assign s_axi_rdata_o = s.rdata;
   assign adc_power_o = s.power;
   assign adc_sample_o = s.sample;
   assign adc_convert_o = s.convert;
   assign adc_clk_o = s.tick;
   assign adc_ext_chan_o = s.ext_chan;
   assign adc_int_src_o = s.int_src;
   assign adc_ref_int_o = s.ref_int;
   assign irq_o = s.irq;

   // Checking helpers: cycles since last converter tick
   logic [7:0] gap;
   logic ck_stable;
   always_ff @(posedge clk_i) begin
      if (launch && s.power && !s.busy && !sys_rst_i) begin
         // First converter clock falls a full period after launch
         gap <= 8'hff;
         ck_stable <= 1'b1;
      end else if (sys_rst_i || s.tick) begin
         gap <= 8'h00;
         ck_stable <= 1'b1;
      end else begin
         gap <= gap + 8'h01;
         if (wr_go && s.aw_addr == `ADCS_OFS_CFG) begin
            ck_stable <= 1'b0;
         end
      end
   end

   sequence seq_launch;
      launch && s.power && !s.busy && s.state == ADCS_IDLE;
   endsequence
   sequence seq_finish;
      done ##1 (!s.busy && s.irqf);
   endsequence

   property p_start_pulse;
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(s.busy) |-> $past(s.start) && !s.start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("busy rose without start pulse");

   property p_busy_set;
      @(posedge clk_i) disable iff (sys_rst_i)
      seq_launch |=> s.busy && s.state == ADCS_SAMPLE ##1 s.busy && s.sample;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not set after launch");

   property p_finish;
      @(posedge clk_i) disable iff (sys_rst_i)
      done |-> seq_finish;
   endproperty
   a_finish: assert property (p_finish) else $error("completion did not clear busy");

   property p_irq_gate;
      @(posedge clk_i) disable iff (sys_rst_i)
      irq_o == (s.irqf && s.ade && s.global_irq_enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

   property p_div_ratio;
      @(posedge clk_i) disable iff (sys_rst_i)
      s.tick && ck_stable && s.busy |-> gap == 8'((9'h001 << s.cksel) - 9'h001);
   endproperty
   a_div_ratio: assert property (p_div_ratio) else $error("converter clock ratio wrong");

   property p_sample_len;
      @(posedge clk_i) disable iff (sys_rst_i)
      tick_now && s.power && s.state == ADCS_SAMPLE && s.phase < 4'h3
      |=> s.state == ADCS_SAMPLE && s.sample && s.phase == $past(s.phase) + 4'h1;
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sampling phase count wrong");

   property p_to_convert;
      @(posedge clk_i) disable iff (sys_rst_i)
      tick_now && s.state == ADCS_SAMPLE && s.phase == 4'h3 && s.power
      |=> s.state == ADCS_CONVERT && s.phase == 4'h0;
   endproperty
   a_to_convert: assert property (p_to_convert) else $error("sample to convert wrong");

   property p_single;
      @(posedge clk_i) disable iff (sys_rst_i)
      capture && !s.accm |=> !s.busy && s.res_hi == (s.fmt ? {4'h0, $past(s.code_s2[11:8])}
         : $past(s.code_s2[11:4]));
   endproperty
   a_single: assert property (p_single) else $error("single conversion result wrong");

   property p_accum_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      capture && s.accm && s.nconv != 4'hf |=> s.busy && s.state == ADCS_SAMPLE && !$rose(s.irqf);
   endproperty
   a_accum_hold: assert property (p_accum_hold) else $error("accumulate ended early");

   property p_power_off;
      @(posedge clk_i) disable iff (sys_rst_i)
      !s.power |=> $stable(s.res_hi) && $stable(s.res_lo) && !s.busy;
   endproperty
   a_power_off: assert property (p_power_off) else $error("result changed while off");

   property p_busy_ro;
      @(posedge clk_i) disable iff (sys_rst_i)
      $rose(s.busy) |-> $past(s.state) == ADCS_IDLE && s.state == ADCS_SAMPLE;
   endproperty
   a_busy_ro: assert property (p_busy_ro) else $error("busy set outside launch");

   property p_route;
      @(posedge clk_i) disable iff (sys_rst_i)
      (s.insel == 3'h0 || s.insel >= 3'h5) |=> adc_int_src_o == 3'h0 || $changed(s.insel);
   endproperty
   a_route: assert property (p_route) else $error("external routing wrong");
endmodule

/* File: verification/adcs_analog_model.sv */
module adcs_analog_model (
   input wire logic clk_i,
   input wire logic clear_i,
   input wire logic adc_power_i,
   input wire logic adc_sample_i,
   input wire logic adc_convert_i,
   input wire logic adc_clk_i,
   input wire adcs_pkg::adcs_code_t level_i,
   output adcs_pkg::adcs_code_t adc_code_o,
   output int sample_ticks_o,
   output int conv_ticks_o,
   output int conv_count_o,
   output int tick_gap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import adcs_pkg::*;
   logic was_sample = 1'b0;
   int gap = 0;
   initial begin
      adc_code_o = '0;
      sample_ticks_o = 0;
      conv_ticks_o = 0;
      conv_count_o = 0;
      tick_gap_o = 0;
   end
   always @(posedge clk_i) begin
      // Outside a conversion the code keeps changing, so a stale capture shows
      if (adc_power_i && (adc_sample_i || adc_convert_i)) begin
         adc_code_o <= level_i;
      end else begin
         adc_code_o <= ~adc_code_o;
      end
      was_sample <= adc_sample_i;
      gap <= adc_clk_i ? 1 : gap + 1;
      if (adc_clk_i) begin
         tick_gap_o <= gap;
      end
      if (clear_i) begin
         sample_ticks_o <= 0;
         conv_ticks_o <= 0;
         conv_count_o <= 0;
      end else begin
         sample_ticks_o <= sample_ticks_o + int'(adc_clk_i && adc_sample_i);
         conv_ticks_o <= conv_ticks_o + int'(adc_clk_i && adc_convert_i);
         conv_count_o <= conv_count_o + int'(adc_sample_i && !was_sample);
      end
   end
endmodule

/* File: verification/adc_conversion_sequencer_tb.sv */
`include "adcs_consts.svh"
`define CHK(g, e) chk(64'(g), 64'(e))
module adc_conversion_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adcs_pkg::*;
   typedef struct {
      logic [2:0] sel;
      logic fmt;
      logic acc;
      adcs_code_t code;
      logic [7:0] hi;
      logic [7:0] lo;
   } adcs_row_s;
   // Settling wait after power-up; value is arbitrary
   localparam int SETTLE = 8;
   adcs_row_s rows [10] = '{'{0, 0, 0, 12'habc, 8'hab, 8'hc0}, '{1, 1, 0, 12'habc, 8'h0a, 8'hbc},
      '{2, 0, 0, 12'hfff, 8'hff, 8'hf0}, '{3, 1, 0, 12'h000, 8'h00, 8'h00},
      '{4, 0, 0, 12'h5a5, 8'h5a, 8'h50}, '{5, 1, 0, 12'h5a5, 8'h05, 8'ha5},
      '{6, 0, 0, 12'h001, 8'h00, 8'h10}, '{7, 1, 0, 12'h800, 8'h08, 8'h00},
      '{0, 0, 1, 12'hfff, 8'hff, 8'hf0}, '{0, 1, 1, 12'h123, 8'h12, 8'h30}};
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic clear = 1'b0;
   adcs_addr_t awaddr = '0;
   adcs_addr_t araddr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   logic [31:0] d;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, pwr, smp, cnv, aclk, ref_int, irq;
   logic [3:0] ext, ch;
   logic [2:0] isrc, insel;
   adcs_code_t level = '0;
   adcs_code_t code;
   int sticks, cticks, ccount, gap, mult;
   int err_count = 0;
   int n_checks = 0;

   adcs_sequencer DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(1'b1), .adc_code_i(code), .adc_power_o(pwr), .adc_sample_o(smp),
      .adc_convert_o(cnv), .adc_clk_o(aclk), .adc_ext_chan_o(ext), .adc_int_src_o(isrc),
      .adc_ref_int_o(ref_int), .irq_o(irq));

   adcs_analog_model MODEL (.clk_i(clk_i), .clear_i(clear), .adc_power_i(pwr),
      .adc_sample_i(smp), .adc_convert_i(cnv), .adc_clk_i(aclk), .level_i(level),
      .adc_code_o(code), .sample_ticks_o(sticks), .conv_ticks_o(cticks),
      .conv_count_o(ccount), .tick_gap_o(gap));

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Channels are released one by one as each is taken
   task automatic wr(input adcs_addr_t a, input logic [7:0] v);
      bit ad, wd;
      ad = 0;
      wd = 0;
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk_i);
         ad |= (awready === 1'b1);
         wd |= (wready === 1'b1);
         if (ad) awvalid <= 1'b0;
         if (wd) wvalid <= 1'b0;
      end while (!(ad && wd));
      do @(posedge clk_i); while (bvalid !== 1'b1);
      r = bresp;
   endtask

   task automatic rd(input adcs_addr_t a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_i); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask

   task automatic launch(input logic fmt, input logic [3:0] c);
      wr(`ADCS_OFS_CTRL, {3'b101, fmt, c});
      wr(`ADCS_OFS_CTRL, {3'b001, fmt, c});
   endtask

   // Bounded poll; a busy flag that never clears shows up as failed checks
   task automatic wait_idle();
      for (int k = 0; k < 3000; k++) begin
         rd(`ADCS_OFS_CTRL);
         if (d[`ADCS_CTRL_BUSY] === 1'b0) break;
      end
      `CHK(d[`ADCS_CTRL_BUSY], 1'b0);
   endtask

   initial begin
      repeat (40000) @(posedge clk_i);
      err_count++;
      results();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         rd(adcs_addr_t'(k * 4));
         `CHK({r, d}, {`ADCS_RESP_OKAY, 24'h0, `ADCS_RST_REG});
      end
      `CHK({pwr, smp, cnv, irq}, 4'h0);
      wr(8'h18, 8'hff);
      `CHK(r, `ADCS_RESP_SLVERR);
      rd(8'h18);
      `CHK({r, d}, {`ADCS_RESP_SLVERR, 32'h0});
      wr(`ADCS_OFS_CTRL, 8'h20);
      repeat (SETTLE) @(posedge clk_i);
      `CHK(pwr, 1'b1);
      wr(`ADCS_OFS_CTRL, 8'h60);
      rd(`ADCS_OFS_CTRL);
      `CHK(d[7:5], 3'b001);
      wr(`ADCS_OFS_CTRL, 8'ha0);
      repeat (20) @(posedge clk_i);
      rd(`ADCS_OFS_CTRL);
      `CHK(d[7:5], 3'b101);
      for (int i = 0; i < 10; i++) begin
         insel = 3'(i);
         ch = (insel >= 1 && insel <= 4) ? 4'(4 + i) : 4'(i % 4);
         mult = rows[i].acc ? 16 : 1;
         wr(`ADCS_OFS_CFG, {insel, 2'(i), rows[i].sel});
         wr(`ADCS_OFS_CREF, {7'h0, rows[i].acc});
         wr(`ADCS_OFS_IRQ, {6'h0, 2'(i)});
         level <= rows[i].code;
         clear <= 1'b1;
         @(posedge clk_i);
         clear <= 1'b0;
         launch(rows[i].fmt, ch);
         rd(`ADCS_OFS_CTRL);
         `CHK(d[`ADCS_CTRL_BUSY], 1'b1);
         wait_idle();
         `CHK(ccount, mult);
         `CHK({sticks, cticks}, {4 * mult, 12 * mult});
         `CHK(gap, 1 << rows[i].sel);
         `CHK(isrc, (insel >= 1 && insel <= 4) ? insel : 3'h0);
         `CHK({ext, ref_int}, {ch, 2'(i) == 2'b01});
         rd(`ADCS_OFS_RHI);
         `CHK(d, rows[i].hi);
         rd(`ADCS_OFS_RLO);
         `CHK(d, rows[i].lo);
         rd(`ADCS_OFS_IRQ);
         `CHK(d[`ADCS_IRQ_FLAG], 1'b1);
         `CHK(irq, i % 4 == 3);
         wr(`ADCS_OFS_IRQ, {6'h0, 2'(i)});
         rd(`ADCS_OFS_IRQ);
         `CHK({d[`ADCS_IRQ_FLAG], irq}, 2'b00);
      end
      // Power drop in mid-conversion must leave the old result in place
      level <= 12'h777;
      wr(`ADCS_OFS_CFG, 8'h07);
      launch(1'b0, 4'h0);
      repeat (100) @(posedge clk_i);
      wr(`ADCS_OFS_CTRL, 8'h00);
      rd(`ADCS_OFS_CTRL);
      `CHK({d[`ADCS_CTRL_BUSY], pwr, smp, cnv}, 4'h0);
      rd(`ADCS_OFS_RHI);
      `CHK(d, 8'h12);
      rd(`ADCS_OFS_RLO);
      `CHK(d, 8'h30);
      rd(`ADCS_OFS_IRQ);
      `CHK({d[`ADCS_IRQ_FLAG], irq}, 2'b00);
      // Reset in mid-conversion must return every register to zero
      wr(`ADCS_OFS_CTRL, 8'h20);
      repeat (SETTLE) @(posedge clk_i);
      launch(1'b1, 4'h3);
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      `CHK({pwr, smp, cnv, aclk, irq}, 5'h00);
      for (int k = 0; k < 6; k++) begin
         rd(adcs_addr_t'(k * 4));
         `CHK({r, d}, {`ADCS_RESP_OKAY, 24'h0, `ADCS_RST_REG});
      end
      results();
   end
endmodule
